// ### src/idfu_pkg.sv
// Shared constants, encodings and carrier types of the floating-point format unit.
package idfu_pkg;

	// ------------------------------------------------------------------
	// Number formats
	// ------------------------------------------------------------------
	localparam logic signed [12:0] DBL_BIAS  = 13'sh03FF;
	localparam logic signed [12:0] SGL_BIAS  = 13'sh007F;
	localparam logic [10:0]        DBL_EMAX  = 11'h7FF;
	localparam logic [10:0]        SGL_EMAX  = 11'h0FF;
	localparam int unsigned        DBL_SIGN  = 63;
	localparam int unsigned        SGL_SIGN  = 31;
	localparam logic [63:0]        DBL_QNAN  = 64'h7FF7_FFFF_FFFF_FFFF;
	localparam logic [63:0]        SGL_QNAN  = 64'h0000_0000_7FBF_FFFF;
	localparam logic [51:0]        MAN_ZERO  = 52'h0_0000_0000_0000;
	localparam logic [51:0]        MAN_LARGE = 52'hF_FFFF_FFFF_FFFF;

	// ------------------------------------------------------------------
	// Exception flag positions
	// ------------------------------------------------------------------
	localparam int unsigned FLG_INX = 0;
	localparam int unsigned FLG_UNF = 1;
	localparam int unsigned FLG_OVF = 2;
	localparam int unsigned FLG_DVZ = 3;
	localparam int unsigned FLG_INV = 4;

	// ------------------------------------------------------------------
	// Latencies in core cycles
	// ------------------------------------------------------------------
	localparam logic [5:0] LAT_FMUL_BASE   = 6'h08;
	localparam logic [5:0] LAT_FMUL_S_FAST = 6'h04;
	localparam logic [5:0] LAT_FMUL_D_FAST = 6'h05;
	localparam logic [5:0] LAT_IMUL_BASE   = 6'h0A;
	localparam logic [5:0] LAT_IMUL_SAVE   = 6'h02;
	localparam logic [5:0] LAT_IDIV        = 6'h23;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_MASK  = 8'h08;
	localparam logic [7:0] ADDR_INFO  = 8'h0C;
	localparam int unsigned CTRL_RM_LSB = 0;
	localparam int unsigned CTRL_EN_LSB = 2;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [5:0] STAT_RESET = 6'h00;
	localparam logic [5:0] MASK_RESET = 6'h00;

	typedef enum logic [1:0] {
		IDFU_OP_FMUL_D = 2'h0,
		IDFU_OP_FMUL_S = 2'h1,
		IDFU_OP_IMUL   = 2'h2,
		IDFU_OP_IDIV   = 2'h3
	} idfu_op_t;

	typedef enum logic [1:0] {
		IDFU_RM_NEAR = 2'h0,
		IDFU_RM_ZERO = 2'h1,
		IDFU_RM_UP   = 2'h2,
		IDFU_RM_DOWN = 2'h3
	} idfu_rmode_t;

	typedef enum logic [1:0] {
		IDFU_ST_IDLE = 2'b01,
		IDFU_ST_BUSY = 2'b10
	} idfu_state_t;

	typedef struct packed {
		idfu_op_t    op;
		logic [63:0] a;
		logic [63:0] b;
	} idfu_req_t;

	typedef struct packed {
		logic [63:0] data;
		logic [4:0]  flags;
		logic        unimp;
		logic        trap;
	} idfu_res_t;

	typedef struct packed {
		logic        sign;
		logic [10:0] expf;
		logic [51:0] man;
		logic        zero;
		logic        den;
		logic        inf;
		logic        nan;
		logic        snan;
	} idfu_unp_t;

endpackage

// ### src/idfu_core.sv
// Floating-point format unit: operand decode, multiply, rounding, exceptions and APB registers.
`timescale 1ns/1ps
`default_nettype none

module idfu_core #(
	parameter bit FAST_MUL  = 1'b0, // Selects the faster multiplier variant.
	parameter bit DOUBLE_EN = 1'b1  // Clear for the single-precision-only variant.
) (
	input  wire logic              SYS_CLK,     // Core clock, 100 MHz.
	input  wire logic              NRST,        // Synchronous reset, active low.
	input  wire logic              PSEL,        // APB select.
	input  wire logic              PENABLE,     // APB access phase.
	input  wire logic              PWRITE,      // APB direction, high for write.
	input  wire logic [7:0]        PADDR,       // APB byte address.
	input  wire logic [31:0]       PWDATA,      // APB write data.
	output var  logic [31:0]       PRDATA,      // APB read data.
	output var  logic              PREADY,      // APB ready.
	output var  logic              PSLVERR,     // APB error on unmapped address.
	input  wire logic              ISSUE_VALID, // Pipeline offers an operation.
	input  wire idfu_pkg::idfu_req_t ISSUE_REQ, // Operation code and operands.
	output var  logic              ISSUE_READY, // Unit can take an operation.
	output var  logic              RES_VALID,   // One-cycle result strobe.
	output var  idfu_pkg::idfu_res_t RES,       // Result, flags and trap requests.
	output var  logic              IRQ          // Level interrupt.
);

	// ------------------------------------------------------------------
	// Operand decode
	// ------------------------------------------------------------------
	function automatic idfu_pkg::idfu_unp_t unpack(input logic [63:0] x, input logic sgl);
		idfu_pkg::idfu_unp_t u;
		logic [10:0]         emax;
		emax   = sgl ? idfu_pkg::SGL_EMAX : idfu_pkg::DBL_EMAX;
		u.sign = sgl ? x[idfu_pkg::SGL_SIGN] : x[idfu_pkg::DBL_SIGN];
		u.expf = sgl ? {3'h0, x[30:23]} : x[62:52];
		u.man  = sgl ? {x[22:0], 29'h0} : x[51:0];
		u.zero = (u.expf == 11'h0) && (u.man == idfu_pkg::MAN_ZERO);
		u.den  = (u.expf == 11'h0) && (u.man != idfu_pkg::MAN_ZERO);
		u.inf  = (u.expf == emax) && (u.man == idfu_pkg::MAN_ZERO);
		u.nan  = (u.expf == emax) && (u.man != idfu_pkg::MAN_ZERO);
		u.snan = u.nan && u.man[51];
		return u;
	endfunction

	function automatic logic [5:0] op_latency(input idfu_pkg::idfu_op_t op);
		case (op)
			idfu_pkg::IDFU_OP_FMUL_D: return FAST_MUL ? idfu_pkg::LAT_FMUL_D_FAST : idfu_pkg::LAT_FMUL_BASE;
			idfu_pkg::IDFU_OP_FMUL_S: return FAST_MUL ? idfu_pkg::LAT_FMUL_S_FAST : idfu_pkg::LAT_FMUL_BASE;
			idfu_pkg::IDFU_OP_IMUL: return FAST_MUL ? 6'(idfu_pkg::LAT_IMUL_BASE - idfu_pkg::LAT_IMUL_SAVE)
				: idfu_pkg::LAT_IMUL_BASE;
			default: return idfu_pkg::LAT_IDIV;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	idfu_pkg::idfu_state_t state_reg, state_next;
	idfu_pkg::idfu_req_t   req_reg, req_next;
	idfu_pkg::idfu_res_t   res_reg, res_next, res_calc;
	logic [5:0]            cnt_reg, cnt_next;
	logic                  ready_reg, ready_next;
	logic                  res_valid_reg, res_valid_next;
	logic [6:0]            ctrl_reg, ctrl_next;
	logic [5:0]            stat_reg, stat_next;
	logic [5:0]            mask_reg, mask_next;
	logic [31:0]           prdata_reg, prdata_next;
	logic                  pready_reg, pready_next;
	logic                  pslverr_reg, pslverr_next;
	logic                  irq_reg, irq_next;
	idfu_pkg::idfu_rmode_t rmode;
	logic [4:0]            trap_en;

	assign rmode   = idfu_pkg::idfu_rmode_t'(ctrl_reg[idfu_pkg::CTRL_RM_LSB +: 2]);
	assign trap_en = ctrl_reg[idfu_pkg::CTRL_EN_LSB +: 5];

	// ------------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------------
	idfu_pkg::idfu_unp_t   ua, ub;
	logic                  sgl, rsign, inexact, rnd_up, to_inf, guard, sticky;
	logic [105:0]          prod, mnorm;
	logic [52:0]           kept, inc;
	logic [53:0]           rsum;
	logic [51:0]           rman;
	logic signed [12:0]    bias, ebiased, emax_s;
	logic [63:0]           imul;

	always_comb begin
		sgl      = (req_reg.op == idfu_pkg::IDFU_OP_FMUL_S);
		ua       = unpack(req_reg.a, sgl);
		ub       = unpack(req_reg.b, sgl);
		rsign    = ua.sign ^ ub.sign;
		bias     = sgl ? idfu_pkg::SGL_BIAS : idfu_pkg::DBL_BIAS;
		emax_s   = $signed({2'b00, sgl ? idfu_pkg::SGL_EMAX : idfu_pkg::DBL_EMAX});
		// The hidden one is restored before multiplying.
		prod     = {1'b1, ua.man} * {1'b1, ub.man};
		mnorm    = prod[105] ? prod : {prod[104:0], 1'b0};
		// Sum of true exponents, rebiased once: (Ea-bias)+(Eb-bias)+bias.
		ebiased  = $signed({2'b00, ua.expf}) + $signed({2'b00, ub.expf}) - bias
			+ (prod[105] ? 13'sh0001 : 13'sh0000);
		kept     = sgl ? {mnorm[105:82], 29'h0} : mnorm[105:53];
		guard    = sgl ? mnorm[81] : mnorm[52];
		sticky   = sgl ? |mnorm[80:0] : |mnorm[51:0];
		inc      = sgl ? 53'h0_0000_2000_0000 : 53'h0_0000_0000_0001;
		inexact  = guard | sticky;
		case (rmode)
			idfu_pkg::IDFU_RM_NEAR: rnd_up = guard & sticky;
			idfu_pkg::IDFU_RM_ZERO: rnd_up = 1'b0;
			idfu_pkg::IDFU_RM_UP: rnd_up = inexact & ~rsign;
			idfu_pkg::IDFU_RM_DOWN: rnd_up = inexact & rsign;
			default: rnd_up = 1'b0;
		endcase
		rsum     = {1'b0, kept} + (rnd_up ? {1'b0, inc} : 54'h0);
		if (rsum[53]) begin
			rman    = rsum[52:1];
			ebiased = ebiased + 13'sh0001;
		end else begin
			rman = rsum[51:0];
		end
		to_inf   = (rmode == idfu_pkg::IDFU_RM_NEAR) || ((rmode == idfu_pkg::IDFU_RM_UP) && !rsign)
			|| ((rmode == idfu_pkg::IDFU_RM_DOWN) && rsign);
		imul     = req_reg.a[31:0] * req_reg.b[31:0];

		res_calc = '0;
		case (req_reg.op)
			idfu_pkg::IDFU_OP_IMUL: begin
				res_calc.data = imul;
			end
			idfu_pkg::IDFU_OP_IDIV: begin
				if (req_reg.b[31:0] == 32'h0000_0000) begin
					res_calc.data               = 64'hFFFF_FFFF_FFFF_FFFF;
					res_calc.flags[idfu_pkg::FLG_DVZ] = 1'b1;
				end else begin
					res_calc.data = {req_reg.a[31:0] % req_reg.b[31:0], req_reg.a[31:0] / req_reg.b[31:0]};
				end
			end
			default: begin
				if (!sgl && !DOUBLE_EN) begin
					res_calc.unimp = 1'b1;
				end else if (ua.snan || ub.snan || (ua.inf && ub.zero) || (ua.zero && ub.inf)) begin
					res_calc.data               = sgl ? idfu_pkg::SGL_QNAN : idfu_pkg::DBL_QNAN;
					res_calc.flags[idfu_pkg::FLG_INV] = 1'b1;
				end else if (ua.nan || ub.nan) begin
					res_calc.data = sgl ? idfu_pkg::SGL_QNAN : idfu_pkg::DBL_QNAN;
				end else if (ua.den || ub.den) begin
					res_calc.unimp = 1'b1;
				end else if (ua.inf || ub.inf || ua.zero || ub.zero) begin
					res_calc.data = sgl ? {32'h0, rsign, (ua.inf || ub.inf) ? 8'hFF : 8'h00, 23'h0}
						: {rsign, (ua.inf || ub.inf) ? idfu_pkg::DBL_EMAX : 11'h0, idfu_pkg::MAN_ZERO};
				end else if (ebiased >= emax_s) begin
					res_calc.flags[idfu_pkg::FLG_OVF] = 1'b1;
					res_calc.flags[idfu_pkg::FLG_INX] = 1'b1;
					// Overflow gives infinity in nearest mode or when rounding runs away from zero, else the largest finite.
					if (sgl) begin
						res_calc.data = {32'h0, rsign, to_inf ? 8'hFF : 8'hFE, to_inf ? 23'h0 : 23'h7F_FFFF};
					end else begin
						res_calc.data = {rsign, to_inf ? idfu_pkg::DBL_EMAX : 11'h7FE,
							to_inf ? idfu_pkg::MAN_ZERO : idfu_pkg::MAN_LARGE};
					end
				end else if (ebiased < 13'sh0001) begin
					// Denormal results are left to software.
					res_calc.unimp                   = 1'b1;
					res_calc.flags[idfu_pkg::FLG_UNF] = 1'b1;
				end else begin
					res_calc.flags[idfu_pkg::FLG_INX] = inexact;
					res_calc.data = sgl ? {32'h0, rsign, ebiased[7:0], rman[51:29]}
						: {rsign, ebiased[10:0], rman};
				end
			end
		endcase
		res_calc.trap = |(res_calc.flags & trap_en);
	end

	// ------------------------------------------------------------------
	// Issue and completion sequencing
	// ------------------------------------------------------------------
	always_comb begin
		state_next     = state_reg;
		req_next       = req_reg;
		cnt_next       = cnt_reg;
		ready_next     = ready_reg;
		res_next       = res_reg;
		res_valid_next = 1'b0;
		case (state_reg)
			idfu_pkg::IDFU_ST_IDLE: begin
				if (ISSUE_VALID && ready_reg) begin
					req_next   = ISSUE_REQ;
					cnt_next   = 6'(op_latency(ISSUE_REQ.op) - 6'h1);
					ready_next = 1'b0;
					state_next = idfu_pkg::IDFU_ST_BUSY;
				end
			end
			idfu_pkg::IDFU_ST_BUSY: begin
				if (cnt_reg == 6'h0) begin
					res_next       = res_calc;
					res_valid_next = 1'b1;
					ready_next     = 1'b1;
					state_next     = idfu_pkg::IDFU_ST_IDLE;
				end else begin
					cnt_next = 6'(cnt_reg - 6'h1);
				end
			end
			default: begin
				state_next = idfu_pkg::IDFU_ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			state_reg     <= idfu_pkg::IDFU_ST_IDLE;
			req_reg       <= '0;
			cnt_reg       <= 6'h0;
			ready_reg     <= 1'b1;
			res_reg       <= '0;
			res_valid_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			req_reg       <= req_next;
			cnt_reg       <= cnt_next;
			ready_reg     <= ready_next;
			res_reg       <= res_next;
			res_valid_reg <= res_valid_next;
		end
	end

	// ------------------------------------------------------------------
	// APB registers and interrupt
	// ------------------------------------------------------------------
	logic access, rd_stat, wr_ctrl, wr_mask;
	logic [5:0] events;

	always_comb begin
		access       = PSEL && PENABLE;
		pready_next  = access && !pready_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		if (access && !pready_reg) begin
			case (PADDR)
				idfu_pkg::ADDR_CTRL: prdata_next = {25'h0, ctrl_reg};
				idfu_pkg::ADDR_STAT: prdata_next = {26'h0, stat_reg};
				idfu_pkg::ADDR_MASK: prdata_next = {26'h0, mask_reg};
				idfu_pkg::ADDR_INFO: prdata_next = {30'h0, DOUBLE_EN, FAST_MUL};
				default: begin
					prdata_next  = 32'h0000_0000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		wr_ctrl   = access && pready_reg && PWRITE && (PADDR == idfu_pkg::ADDR_CTRL);
		wr_mask   = access && pready_reg && PWRITE && (PADDR == idfu_pkg::ADDR_MASK);
		rd_stat   = access && pready_reg && !PWRITE && (PADDR == idfu_pkg::ADDR_STAT);
		ctrl_next = wr_ctrl ? PWDATA[6:0] : ctrl_reg;
		mask_next = wr_mask ? PWDATA[5:0] : mask_reg;
		events    = res_valid_next ? {res_next.unimp, res_next.flags} : 6'h0;
		// Only the bits returned to software are cleared, and new events always land.
		stat_next = (stat_reg & ~(rd_stat ? prdata_reg[5:0] : 6'h0)) | events;
		irq_next  = |(stat_next & mask_next);
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			ctrl_reg    <= idfu_pkg::CTRL_RESET;
			stat_reg    <= idfu_pkg::STAT_RESET;
			mask_reg    <= idfu_pkg::MASK_RESET;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			stat_reg    <= stat_next;
			mask_reg    <= mask_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg     <= irq_next;
		end
	end

	assign PRDATA      = prdata_reg;
	assign PREADY      = pready_reg;
	assign PSLVERR     = pslverr_reg;
	assign ISSUE_READY = ready_reg;
	assign RES_VALID   = res_valid_reg;
	assign RES         = res_reg;
	assign IRQ         = irq_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	logic [5:0] chk_cnt;
	logic [5:0] chk_exp;
	idfu_pkg::idfu_unp_t chk_a, chk_b;

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			chk_cnt <= 6'h0;
		end else if (ISSUE_VALID && ISSUE_READY) begin
			chk_cnt <= 6'h0;
		end else if (state_reg == idfu_pkg::IDFU_ST_BUSY) begin
			chk_cnt <= 6'(chk_cnt + 6'h1);
		end
	end

	always_comb begin
		chk_a = unpack(req_reg.a, 1'b0);
		chk_b = unpack(req_reg.b, 1'b0);
		case (req_reg.op)
			idfu_pkg::IDFU_OP_FMUL_D: chk_exp = FAST_MUL ? 6'h05 : 6'h08;
			idfu_pkg::IDFU_OP_FMUL_S: chk_exp = FAST_MUL ? 6'h04 : 6'h08;
			idfu_pkg::IDFU_OP_IMUL: chk_exp = FAST_MUL ? 6'h08 : 6'h0A;
			default: chk_exp = 6'h23;
		endcase
	end

	sequence s_setup;
		PSEL && !PENABLE;
	endsequence

	sequence s_access;
		PSEL && PENABLE;
	endsequence

	a_op_latency: assert property (RES_VALID |-> chk_cnt == chk_exp)
		else $error("Result arrived at the wrong latency.");
	a_apb_answer: assert property (s_setup ##1 s_access |=> PREADY ##1 !PREADY)
		else $error("APB answer not one wait state.");
	a_trap_enabled: assert property (RES_VALID |-> RES.trap == |(RES.flags & $past(trap_en)))
		else $error("Trap request does not follow enabled flags.");
	a_snan_invalid: assert property (
		RES_VALID && DOUBLE_EN && req_reg.op == idfu_pkg::IDFU_OP_FMUL_D
		&& (chk_a.snan || chk_b.snan) |-> RES.flags[idfu_pkg::FLG_INV])
		else $error("Signalling NaN did not raise invalid.");
	a_qnan_quiet: assert property (
		RES_VALID && DOUBLE_EN && req_reg.op == idfu_pkg::IDFU_OP_FMUL_D
		&& chk_a.nan && !chk_a.snan && !chk_b.snan |-> RES.flags == 5'h00 && RES.data[62:52] == 11'h7FF
		&& !RES.data[51])
		else $error("Quiet NaN raised a flag or lost NaN.");
	a_ovf_inf: assert property (
		RES_VALID && RES.flags[idfu_pkg::FLG_OVF] && req_reg.op == idfu_pkg::IDFU_OP_FMUL_D
		&& $past(rmode) == idfu_pkg::IDFU_RM_NEAR |-> RES.data[62:0] == {11'h7FF, 52'h0_0000_0000_0000})
		else $error("Overflow in nearest mode is not infinity.");
	a_single_only: assert property (
		RES_VALID && !DOUBLE_EN && req_reg.op == idfu_pkg::IDFU_OP_FMUL_D |-> RES.unimp)
		else $error("Double operation ran on single-only variant.");
	a_stat_sticky: assert property (
		RES_VALID |-> (stat_reg[4:0] & RES.flags) == RES.flags ##1
		(stat_reg[4:0] & $past(RES.flags)) == $past(RES.flags) || $past(rd_stat, 1))
		else $error("Raised flag missing from status.");
	a_irq_level: assert property (IRQ |-> |(stat_reg & mask_reg))
		else $error("Interrupt high with no unmasked status.");

endmodule

`default_nettype wire

// ### verification/idfu_pipe_model.sv
// Pipeline-side model that offers one operation at a time and collects its result.
`timescale 1ns/1ps
`default_nettype none

module idfu_pipe_model (
	input  wire logic                sys_clk,     // Core clock.
	input  wire logic                issue_ready, // Unit can take an operation.
	input  wire logic                res_valid,   // Result strobe.
	input  wire idfu_pkg::idfu_res_t res,         // Result bundle.
	output var  logic                issue_valid, // Operation offered.
	output var  idfu_pkg::idfu_req_t issue_req    // Offered operation.
);
	initial begin
		issue_valid = 1'b0;
		issue_req = '0;
	end

	// The offer waits gap + 1 edges, is held until taken, then the edges up to the strobe are counted.
	// Operands are inverted once taken so that a stale value is never mistaken for a live one.
	task automatic issue(input idfu_pkg::idfu_op_t op, input logic [63:0] a, input logic [63:0] b,
			input int gap, output idfu_pkg::idfu_res_t r, output int lat);
		int n;
		n = 0;
		lat = -1;
		repeat (gap + 1) @(posedge sys_clk);
		issue_valid <= 1'b1;
		issue_req <= '{op, a, b};
		do @(posedge sys_clk); while (issue_ready !== 1'b1);
		issue_valid <= 1'b0;
		issue_req <= idfu_pkg::idfu_req_t'(~{op, a, b});
		do begin
			@(posedge sys_clk);
			n++;
		end while (res_valid !== 1'b1 && n < 100);
		r = res;
		if (res_valid === 1'b1) begin
			lat = n - 1;
		end
	endtask
endmodule
`default_nettype wire

// ### verification/test_ieee_double_format_unit.sv
// Self-checking bench of the floating-point format unit.
`timescale 1ns/1ps
`default_nettype none

module test_ieee_double_format_unit;
	localparam idfu_pkg::idfu_op_t FD = idfu_pkg::IDFU_OP_FMUL_D;
	localparam idfu_pkg::idfu_op_t FS = idfu_pkg::IDFU_OP_FMUL_S;
	localparam logic [63:0] ONE  = 64'h3FF0_0000_0000_0000;
	localparam logic [63:0] TWO  = 64'h4000_0000_0000_0000;
	localparam logic [63:0] BIG  = 64'h7FE0_0000_0000_0000;
	localparam logic [63:0] INF  = 64'h7FF0_0000_0000_0000;
	localparam logic [63:0] ULP1 = 64'h3FF0_0000_0000_0001;
	localparam logic [63:0] QN   = idfu_pkg::DBL_QNAN;
	localparam logic [4:0]  FX   = 5'h01 << idfu_pkg::FLG_INX;
	localparam logic [4:0]  FO   = 5'h01 << idfu_pkg::FLG_OVF;
	localparam logic [4:0]  FZ   = 5'h01 << idfu_pkg::FLG_DVZ;
	localparam logic [4:0]  FI   = 5'h01 << idfu_pkg::FLG_INV;
	localparam int          LF   = int'(idfu_pkg::LAT_FMUL_BASE);
	localparam int          LD   = int'(idfu_pkg::LAT_IDIV);
	localparam int          LI   = int'(idfu_pkg::LAT_IMUL_BASE);
	localparam int          LFS  = int'(idfu_pkg::LAT_FMUL_S_FAST);
	localparam int          LFD  = int'(idfu_pkg::LAT_FMUL_D_FAST);
	localparam int          LFI  = LI - int'(idfu_pkg::LAT_IMUL_SAVE);

	logic                sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic                issue_valid, issue_ready, res_valid, irq, l_valid;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, d;
	idfu_pkg::idfu_req_t issue_req;
	idfu_pkg::idfu_res_t res, r, l_res;
	int                  lat, n_errors, tests_run;

	idfu_core #(.FAST_MUL(1'b0), .DOUBLE_EN(1'b1)) i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ISSUE_VALID(issue_valid), .ISSUE_REQ(issue_req), .ISSUE_READY(issue_ready),
		.RES_VALID(res_valid), .RES(res), .IRQ(irq));
	idfu_pipe_model i_pipe (.sys_clk(sys_clk), .issue_ready(issue_ready), .res_valid(res_valid), .res(res),
		.issue_valid(issue_valid), .issue_req(issue_req));
	// The fast single-only variant shares every input; it is never busy when i_dut takes an operation.
	idfu_core #(.FAST_MUL(1'b1), .DOUBLE_EN(1'b0)) i_dut_lite (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(),
		.ISSUE_VALID(issue_valid), .ISSUE_REQ(issue_req), .ISSUE_READY(), .RES_VALID(l_valid), .RES(l_res),
		.IRQ());

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		tests_run++;
		if (got !== ex) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic op_chk(input idfu_pkg::idfu_op_t op, input logic [63:0] a, input logic [63:0] b,
			input logic [63:0] ed, input logic [4:0] ef, input int el);
		i_pipe.issue(op, a, b, 0, r, lat);
		chk("result data", ed, r.data);
		chk("flags", 64'(ef), 64'(r.flags));
		chk("latency", 64'(el), 64'(lat));
	endtask

	// Runs one operation on both variants; the fast one is timed from the shared take edge to its own strobe.
	task automatic lite_chk(input idfu_pkg::idfu_op_t op, input logic [63:0] a, input logic [63:0] b,
			input logic [63:0] ed, input int el, input logic [63:0] ld, input logic lu, input int ll);
		int n;
		n = 0;
		fork
			op_chk(op, a, b, ed, 5'h00, el);
			begin
				do @(posedge sys_clk); while (!(issue_valid && issue_ready));
				do begin
					@(posedge sys_clk);
					n++;
				end while (l_valid !== 1'b1 && n < 100);
				chk("lite data", ld, l_res.data);
				chk("lite unimp", 64'(lu), 64'(l_res.unimp));
				chk("lite latency", 64'(ll), 64'(n - 1));
			end
		join
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		chk("ready after reset", 64'h1, 64'(issue_ready));
		apb(1'b0, idfu_pkg::ADDR_STAT, 32'h0, d);
		chk("stat reset", 64'h0, 64'(d));
		apb(1'b1, idfu_pkg::ADDR_INFO, 32'hFFFF_FFFF, d);
		apb(1'b0, idfu_pkg::ADDR_INFO, 32'h0, d);
		chk("info", 64'h2, 64'(d));
		apb(1'b0, 8'h10, 32'h0, d);
		chk("unmapped error", 64'h1, 64'(err));
		apb(1'b1, idfu_pkg::ADDR_CTRL, 32'hFFFF_FFFF, d);
		apb(1'b0, idfu_pkg::ADDR_CTRL, 32'h0, d);
		chk("ctrl width", 64'h7F, 64'(d));
		apb(1'b1, idfu_pkg::ADDR_CTRL, 32'h0, d);
	endtask

	task automatic t_format();
		op_chk(FD, 64'h3FF8_0000_0000_0000, TWO, 64'h4008_0000_0000_0000, 5'h00, LF);
		op_chk(FD, 64'hBFF8_0000_0000_0000, TWO, 64'hC008_0000_0000_0000, 5'h00, LF);
		op_chk(FS, 64'h3FC0_0000, 64'h4000_0000, 64'h4040_0000, 5'h00, LF);
		op_chk(FD, BIG, ONE, BIG, 5'h00, LF);
		op_chk(idfu_pkg::IDFU_OP_IMUL, 64'h7, 64'h6, 64'h2A, 5'h00, int'(idfu_pkg::LAT_IMUL_BASE));
		op_chk(idfu_pkg::IDFU_OP_IDIV, 64'h64, 64'h7, 64'h0000_0002_0000_000E, 5'h00, LD);
		op_chk(idfu_pkg::IDFU_OP_IDIV, 64'h5, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, FZ, LD);
	endtask

	task automatic t_round();
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, idfu_pkg::ADDR_CTRL, 32'(m), d);
			op_chk(FD, 64'h3FF8_0000_0000_0000, ULP1, 64'h3FF8_0000_0000_0001 + 64'(m == 2), FX, LF);
			op_chk(FD, 64'hBFF8_0000_0000_0000, ULP1, 64'hBFF8_0000_0000_0001 + 64'(m == 3), FX, LF);
			op_chk(FD, BIG, TWO, (m % 2 == 1) ? 64'h7FEF_FFFF_FFFF_FFFF : INF, FO | FX, LF);
		end
		apb(1'b1, idfu_pkg::ADDR_CTRL, 32'h0, d);
		op_chk(FD, 64'h3FFC_0000_0000_0000, ULP1, 64'h3FFC_0000_0000_0002, FX, LF);
	endtask

	task automatic t_special();
		op_chk(FD, INF, 64'h0, QN, FI, LF);
		op_chk(FD, 64'h7FF8_0000_0000_0001, ONE, QN, FI, LF);
		op_chk(FD, ONE, 64'h7FF8_0000_0000_0000, QN, FI, LF);
		op_chk(FD, 64'h7FF0_0000_0000_0001, ONE, QN, 5'h00, LF);
		op_chk(FS, 64'h7FC0_0001, 64'h3F80_0000, idfu_pkg::SGL_QNAN, FI, LF);
		op_chk(FD, 64'hFFF0_0000_0000_0000, TWO, 64'hFFF0_0000_0000_0000, 5'h00, LF);
		op_chk(FD, 64'h8000_0000_0000_0000, TWO, 64'h8000_0000_0000_0000, 5'h00, LF);
		i_pipe.issue(FD, 64'h1, ONE, 0, r, lat);
		chk("denormal data", 64'h0, r.data);
		chk("unimp", 64'h1, 64'(r.unimp));
	endtask

	task automatic t_traps();
		apb(1'b0, idfu_pkg::ADDR_STAT, 32'h0, d);
		apb(1'b1, idfu_pkg::ADDR_CTRL, 32'(FO) << idfu_pkg::CTRL_EN_LSB, d);
		apb(1'b1, idfu_pkg::ADDR_MASK, 32'(FO), d);
		op_chk(FD, 64'h3FF8_0000_0000_0000, ULP1, 64'h3FF8_0000_0000_0001, FX, LF);
		chk("trap", 64'h0, 64'(r.trap));
		chk("irq", 64'h0, 64'(irq));
		i_pipe.issue(FD, BIG, TWO, 3, r, lat);
		chk("trap", 64'h1, 64'(r.trap));
		chk("irq", 64'h1, 64'(irq));
		apb(1'b0, idfu_pkg::ADDR_STAT, 32'h0, d);
		chk("stat", 64'(FO | FX), 64'(d));
		apb(1'b0, idfu_pkg::ADDR_STAT, 32'h0, d);
		chk("stat cleared", 64'h0, 64'(d));
		chk("irq", 64'h0, 64'(irq));
		apb(1'b1, idfu_pkg::ADDR_MASK, 32'h0, d);
		i_pipe.issue(FD, BIG, TWO, 0, r, lat);
		chk("irq", 64'h0, 64'(irq));
		apb(1'b1, idfu_pkg::ADDR_CTRL, 32'h7C, d);
		op_chk(FD, 64'h3FF8_0000_0000_0000, ULP1, 64'h3FF8_0000_0000_0001, FX, LF);
		chk("trap", 64'h1, 64'(r.trap));
	endtask

	task automatic t_lite();
		lite_chk(FS, 64'h3FC0_0000, 64'h4000_0000, 64'h4040_0000, LF, 64'h4040_0000, 1'b0, LFS);
		lite_chk(idfu_pkg::IDFU_OP_IMUL, 64'h7, 64'h6, 64'h2A, LI, 64'h2A, 1'b0, LFI);
		lite_chk(FD, 64'h3FF8_0000_0000_0000, TWO, 64'h4008_0000_0000_0000, LF, 64'h0, 1'b1, LFD);
	endtask

	// ------------------------------------------------------------------
	// Clock, sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_format();
		t_round();
		t_special();
		t_traps();
		t_lite();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
